// *** design/plcic_ctrl.sv ***
// Purpose: interrupt request latching, masking, priority and dispatch
// Assumes: inputs synchronous to clk_sys_in, sequencer pulses task done
// Notes: operations are register writes of {identifier, control}
// Summary of operation
// - start with inputs masked, timer stopped
// - set-mask masks sources, loads scheduled interval
// - clear op keeps/clears requests, sets first delay
// - global disable blocks every interrupt task
// - global enable lets tasks run again
// - input tasks before scheduled task
// - lowest task number first within level
// - only input bits 2 to 7 interrupt
// - unmasking discards all latched input requests
// - one latched request per source, extras absorbed
// - request held until done, edges ignored meanwhile
// - scheduled interval counted in 0.1 ms ticks
// - set-mask restart resets timer for exact interval
// - keep longest task time in 0.1 ms units
// - longest task number coded 8000 to 800f
// - bit 15 set at first interrupt, cleared at start
// - input edge per selected polarity raises request
// - control 0 unmasks or rising, 1 masks or falling
// - changing edge selection discards input requests
// - interval 0 stops, 10..9999 restarts, else error
module plcic_ctrl
#(
   parameter int TIME_W = 16
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // input terminals, word 0
   input wire logic [15:0] in_word0_in,
   // task sequencer
   input wire logic task_done_in,
   output logic task_start_out,
   output logic [3:0] task_num_out,
   output logic task_busy_out
);
   import plcic_pkg::*;
   if (TIME_W != 16) begin : g_chk
      $error("TIME_W must be 16 to fit the time word");
   end
   function automatic logic in_range(input logic [15:0] v,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction
   function automatic logic [2:0] lowest_bit(input logic [5:0] v);
      lowest_bit = 3'h0;
      for (int i = IN_COUNT - 1; i >= 0; i--) begin
         if (v[i]) begin
            lowest_bit = 3'(i);
         end
      end
   endfunction
   plcic_state_t state_reg, state_next;
   logic [5:0] mask_reg, mask_next;
   logic [5:0] edge_reg, edge_next;
   logic [5:0] pend_reg, pend_next;
   logic [5:0] prev_reg;
   logic pend_sched_reg, pend_sched_next;
   logic ge_reg, ge_next;
   logic err_reg, err_next;
   logic sched_on_reg, sched_on_next;
   logic [13:0] interval_reg, interval_next;
   logic [13:0] target_reg, target_next;
   logic [13:0] first_reg, first_next;
   logic [13:0] sched_cnt_reg, sched_cnt_next;
   logic [11:0] presc_reg;
   logic [TIME_W-1:0] run_ticks_reg, run_ticks_next;
   logic [15:0] max_time_reg, max_time_next;
   logic [15:0] max_task_reg, max_task_next;
   logic first_done_reg, first_done_next;
   logic [3:0] cur_reg, cur_next;
   logic start_reg, busy_reg;
   logic [31:0] rdata_reg;
   // operation decode
   wire [15:0] op_id = reg_wdata_in[31:16];
   wire [15:0] op_ctl = reg_wdata_in[15:0];
   wire wr_set = reg_wr_in && (reg_addr_in == OFS_SET_MASK);
   wire wr_clr = reg_wr_in && (reg_addr_in == OFS_CLEAR);
   wire wr_dis = reg_wr_in && (reg_addr_in == OFS_DISABLE);
   wire wr_en = reg_wr_in && (reg_addr_in == OFS_ENABLE);
   wire id_mask = in_range(op_id, ID_MASK_LO, ID_MASK_HI);
   wire id_edge = in_range(op_id, ID_EDGE_LO, ID_EDGE_HI);
   wire id_sched = (op_id == ID_SCHED_A) || (op_id == ID_SCHED_B);
   wire [15:0] mask_off = op_id - ID_MASK_LO;
   wire [15:0] edge_off = op_id - ID_EDGE_LO;
   wire [2:0] mask_idx = mask_off[2:0];
   wire [2:0] edge_idx = edge_off[2:0];
   wire ctl_bit = (op_ctl == CTL_ONE);
   wire ctl_ok = (op_ctl == CTL_ZERO) || ctl_bit;
   wire sched_ok = in_range(op_ctl, SCHED_MIN, SCHED_MAX);
   wire op_unmask = wr_set && id_mask && (op_ctl == CTL_ZERO);
   wire op_edge_chg = wr_set && id_edge && ctl_ok &&
                      (edge_reg[edge_idx] != ctl_bit);
   wire sched_stop = wr_set && id_sched && (op_ctl == CTL_ZERO);
   wire sched_start = wr_set && id_sched && sched_ok;
   wire sched_bad = wr_set && id_sched && !sched_ok &&
                    (op_ctl != CTL_ZERO);
   wire clr_in_op = wr_clr && id_mask && ctl_ok;
   wire clr_sched = wr_clr && id_sched;
   wire op_err = (wr_set && !(id_mask || id_edge || id_sched)) ||
                 (wr_set && (id_mask || id_edge) && !ctl_ok) ||
                 sched_bad ||
                 (wr_clr && !(id_mask || id_sched)) ||
                 (wr_clr && id_mask && !ctl_ok);
   wire any_op = wr_set || wr_clr;

   // input edges
   // input bits only
   wire [5:0] in_bits = in_word0_in[IN_FIRST_BIT +: IN_COUNT];
   wire [5:0] rise = in_bits & ~prev_reg;
   wire [5:0] fall = ~in_bits & prev_reg;
   wire [5:0] edge_hit = (rise & ~edge_reg) | (fall & edge_reg);
   wire cur_in = (cur_reg != SCHED_TASK);
   wire [3:0] cur_off = cur_reg - IN_TASK_BASE;
   wire [5:0] active_in = (busy_reg && cur_in) ?
                          6'(6'h01 << cur_off[2:0]) : 6'h00;
   wire [5:0] new_req = edge_hit & ~mask_reg & ~active_in;
   wire discard = op_unmask || op_edge_chg ||
                  (clr_in_op && ctl_bit);
   wire done_ok = (state_reg == S_RUN) && task_done_in;

   wire tick = (presc_reg == TICK_LAST);
   wire sched_hit = sched_on_reg && tick &&
                    ((sched_cnt_reg + 14'h0001) >= target_reg);

   wire [5:0] cand_in = pend_reg & ~mask_reg;
   wire cand_sched = pend_sched_reg && sched_on_reg;
   wire grant = ge_reg && (state_reg == S_IDLE) &&
                ((|cand_in) || cand_sched);
   wire [3:0] grant_num = (|cand_in) ?
                          (IN_TASK_BASE + {1'b0, lowest_bit(cand_in)}) :
                          SCHED_TASK;
   wire longer = run_ticks_reg > max_time_reg;
   always_comb begin
      mask_next = mask_reg;
      edge_next = edge_reg;
      pend_next = pend_reg;
      if (wr_set && id_mask && ctl_ok) begin
         mask_next[mask_idx] = ctl_bit;
      end
      if (wr_set && id_edge && ctl_ok) begin
         edge_next[edge_idx] = ctl_bit;
      end
      if (discard) begin
         pend_next = 6'h00;
      end
      if (done_ok && cur_in) begin
         pend_next = pend_next & ~active_in;
      end
      // one request per source; set wins over clear
      pend_next = pend_next | new_req;
   end

   always_comb begin
      sched_on_next = sched_on_reg;
      interval_next = interval_reg;
      target_next = target_reg;
      first_next = first_reg;
      sched_cnt_next = sched_cnt_reg;
      pend_sched_next = pend_sched_reg;
      if (clr_sched) begin
         first_next = op_ctl[13:0];
      end
      if (done_ok && !cur_in) begin
         pend_sched_next = 1'b0;
      end
      // count, latch and reload; a hit beats a same-cycle done
      if (tick && sched_on_reg) begin
         sched_cnt_next = sched_cnt_reg + 14'h0001;
      end
      if (sched_hit) begin
         sched_cnt_next = 14'h0000;
         target_next = interval_reg;
         pend_sched_next = 1'b1;
      end
      if (sched_stop) begin
         sched_on_next = 1'b0;
      end
      if (sched_start) begin
         sched_on_next = 1'b1;
         interval_next = op_ctl[13:0];
         sched_cnt_next = 14'h0000;
         target_next = (first_reg != 14'h0000) ? first_reg : op_ctl[13:0];
         first_next = 14'h0000;
      end
   end

   always_comb begin
      state_next = state_reg;
      cur_next = cur_reg;
      run_ticks_next = run_ticks_reg;
      max_time_next = max_time_reg;
      max_task_next = max_task_reg;
      first_done_next = first_done_reg;
      case (state_reg)
         S_IDLE: begin
            if (grant) begin
               state_next = S_ISSUE;
               cur_next = grant_num;
               run_ticks_next = '0;
            end
         end
         S_ISSUE: begin
            state_next = S_RUN;
         end
         S_RUN: begin
            if (tick && (run_ticks_reg != '1)) begin
               run_ticks_next = run_ticks_reg + 16'h0001;
            end
            if (task_done_in) begin
               state_next = S_IDLE;
               if (longer || !first_done_reg) begin
                  max_time_next = run_ticks_reg;
                  max_task_next = TASK_TAG | {12'h000, cur_reg};
               end
               first_done_next = 1'b1;
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   always_comb begin
      ge_next = ge_reg;
      if (wr_dis) begin
         ge_next = 1'b0;
      end
      if (wr_en) begin
         ge_next = 1'b1;
      end
   end

   assign err_next = any_op ? op_err : err_reg;

   wire [31:0] status_w = {9'h000, err_reg, ge_reg, sched_on_reg,
                           busy_reg, pend_sched_reg, pend_reg,
                           edge_reg, mask_reg};
   wire [31:0] read_mux =
      (reg_addr_in == OFS_MAX_TIME) ? {16'h0000, max_time_reg} :
      (reg_addr_in == OFS_MAX_TASK) ? {16'h0000, max_task_reg} :
      (reg_addr_in == OFS_STATUS) ? status_w : 32'h00000000;

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mask_reg <= MASK_RESET;
         edge_reg <= EDGE_RESET;
         pend_reg <= 6'h00;
         prev_reg <= 6'h00;
         ge_reg <= 1'b1;
         err_reg <= 1'b0;
      end else begin
         mask_reg <= mask_next;
         edge_reg <= edge_next;
         pend_reg <= pend_next;
         prev_reg <= in_bits;
         ge_reg <= ge_next;
         err_reg <= err_next;
      end
   end

   // prescaler restarts with the timer so the first period is whole
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         presc_reg <= 12'h000;
      end else if (tick || sched_start) begin
         presc_reg <= 12'h000;
      end else begin
         presc_reg <= presc_reg + 12'h001;
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sched_on_reg <= 1'b0;
         interval_reg <= 14'h0000;
         target_reg <= 14'h0000;
         first_reg <= 14'h0000;
         sched_cnt_reg <= 14'h0000;
         pend_sched_reg <= 1'b0;
      end else begin
         sched_on_reg <= sched_on_next;
         interval_reg <= interval_next;
         target_reg <= target_next;
         first_reg <= first_next;
         sched_cnt_reg <= sched_cnt_next;
         pend_sched_reg <= pend_sched_next;
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_reg <= S_IDLE;
         cur_reg <= 4'h0;
         run_ticks_reg <= '0;
         max_time_reg <= WORD_RESET;
         max_task_reg <= WORD_RESET;
         first_done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cur_reg <= cur_next;
         run_ticks_reg <= run_ticks_next;
         max_time_reg <= max_time_next;
         max_task_reg <= max_task_next;
         first_done_reg <= first_done_next;
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         start_reg <= 1'b0;
         busy_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else begin
         start_reg <= grant;
         busy_reg <= (state_next != S_IDLE);
         rdata_reg <= reg_rd_in ? read_mux : 32'h00000000;
      end
   end

   assign reg_rdata_out = rdata_reg;
   assign task_start_out = start_reg;
   assign task_num_out = cur_reg;
   assign task_busy_out = busy_reg;

   start_masked_a: assert property (
      @(posedge clk_sys_in) $fell(sys_rst_in) |->
         (mask_reg == MASK_RESET) && !sched_on_reg)
      else $error("sources not masked at start");
   gdis_block_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      (!ge_reg && state_reg == S_IDLE) |=> !task_start_out)
      else $error("task started while globally disabled");
   input_first_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      (grant && (|cand_in)) |=> task_num_out != SCHED_TASK)
      else $error("scheduled task beat an input task");
   lowest_first_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      (grant && cand_in[0]) |=> (task_num_out == 4'h2) && task_start_out)
      else $error("lowest numbered task not first");
   unmask_discard_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      (op_unmask && (new_req == 6'h00)) |=> pend_reg == 6'h00)
      else $error("latched inputs kept after unmask");
   held_running_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      (state_reg == S_RUN && |(pend_reg & active_in) && !task_done_in &&
         !discard) |=> (pend_reg & $past(active_in)) != 6'h00)
      else $error("request dropped before task done");
   sched_zero_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      sched_stop |=> !sched_on_reg ##1 !pend_sched_reg || !sched_on_reg)
      else $error("timer still running after zero interval");
   sched_error_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      sched_bad |=> err_reg && $stable(interval_reg))
      else $error("bad interval accepted");
   task_code_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      first_done_reg |-> max_task_reg[15:4] == 12'h800)
      else $error("task number code out of range");
   start_pulse_a: assert property (
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      task_start_out |-> task_busy_out ##1 !task_start_out)
      else $error("start not a single pulse while busy");
endmodule

// *** design/plcic_pkg.sv ***
// Purpose: shared constants and types of the interrupt control block
// Assumes: 25 MHz system clock, 32-bit register port, byte offsets
// Notes: operation codes follow the documented identifier numbers
package plcic_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_SET_MASK = 8'h00;
   localparam logic [7:0] OFS_CLEAR = 8'h04;
   localparam logic [7:0] OFS_DISABLE = 8'h08;
   localparam logic [7:0] OFS_ENABLE = 8'h0c;
   localparam logic [7:0] OFS_MAX_TIME = 8'h10;
   localparam logic [7:0] OFS_MAX_TASK = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   // operation identifiers and control values
   localparam logic [15:0] ID_MASK_LO = 16'h0066;
   localparam logic [15:0] ID_MASK_HI = 16'h006b;
   localparam logic [15:0] ID_EDGE_LO = 16'h0070;
   localparam logic [15:0] ID_EDGE_HI = 16'h0075;
   localparam logic [15:0] ID_SCHED_A = 16'h0004;
   localparam logic [15:0] ID_SCHED_B = 16'h000e;
   localparam logic [15:0] CTL_ZERO = 16'h0000;
   localparam logic [15:0] CTL_ONE = 16'h0001;
   localparam logic [15:0] SCHED_MIN = 16'h000a;
   localparam logic [15:0] SCHED_MAX = 16'h270f;
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int TICK_NS = 100000;
   localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
   // sources, tasks and reset values
   localparam int IN_FIRST_BIT = 2;
   localparam int IN_COUNT = 6;
   localparam logic [3:0] SCHED_TASK = 4'h1;
   localparam logic [3:0] IN_TASK_BASE = 4'h2;
   localparam logic [15:0] TASK_TAG = 16'h8000;
   localparam logic [5:0] MASK_RESET = 6'h3f;
   localparam logic [5:0] EDGE_RESET = 6'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_ISSUE = 2'b01,
      S_RUN = 2'b11
   } plcic_state_t;
endpackage

// *** sim/plc_interrupt_control_bench.sv ***
// Purpose: self-checking bench of the interrupt control block
// Assumes: sequencer model answers every dispatched task
// Notes: scheduled checks wait a full 1 ms interval or a 0.3 ms first delay of real ticks
module plc_interrupt_control_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import plcic_pkg::*;
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] s;
   } plcic_row_t;
   // write, then status bits 22:20 and 11:0 expected
   localparam plcic_row_t ROWS [19] = '{
      '{8'h00, 32'h0066_0001, 32'h0020_003f},
      '{8'h00, 32'h0066_0002, 32'h0060_003f},
      '{8'h00, 32'h0065_0000, 32'h0060_003f},
      '{8'h00, 32'h0067_0000, 32'h0020_003d},
      '{8'h00, 32'h0075_0001, 32'h0020_083d},
      '{8'h00, 32'h0075_0000, 32'h0020_003d},
      '{8'h00, 32'h0004_0009, 32'h0060_003d},
      '{8'h00, 32'h000e_2710, 32'h0060_003d},
      '{8'h00, 32'h0004_000a, 32'h0030_003d},
      '{8'h00, 32'h000e_0000, 32'h0020_003d},
      '{8'h00, 32'h000e_270f, 32'h0030_003d},
      '{8'h00, 32'h0004_0000, 32'h0020_003d},
      '{8'h04, 32'h0004_0000, 32'h0020_003d},
      '{8'h04, 32'h0070_0000, 32'h0060_003d},
      '{8'h00, 32'h0067_0001, 32'h0020_003f},
      '{8'h08, 32'h0000_0000, 32'h0000_003f},
      '{8'h0c, 32'h0000_0000, 32'h0020_003f},
      '{8'h10, 32'h1234_5678, 32'h0020_003f},
      '{8'h1c, 32'h1234_5678, 32'h0020_003f}
   };
   logic clk_sys_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] rdata;
   logic [15:0] in_w = 16'h0000;
   logic [15:0] run_len = 16'h0028;
   logic task_done;
   logic task_start;
   logic task_busy;
   logic [3:0] task_num;
   logic [3:0] order [$];
   logic [31:0] v;
   int mismatches = 0;
   int checked = 0;

   always #20 clk_sys_in = ~clk_sys_in;

   plcic_ctrl #(.TIME_W(16)) dut_u (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
      .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
      .in_word0_in(in_w), .task_done_in(task_done),
      .task_start_out(task_start), .task_num_out(task_num),
      .task_busy_out(task_busy)
   );
   plcic_seq_model seq_u (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .start_in(task_start), .run_len_in(run_len), .done_out(task_done)
   );

   // dispatch log, sampled before the edge's own updates land
   always @(posedge clk_sys_in) begin
      if (task_start === 1'b1) order.push_back(task_num);
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one idle cycle after each strobe keeps back-to-back strobes as separate one-cycle pulses
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic rd(input logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd <= 1'b0;
      #1;
      v = rdata;
      @(posedge clk_sys_in);
   endtask
   task automatic rdx(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
      rd(a);
      check(what, exp, v);
   endtask
   task automatic tog(input int b);
      in_w[b] <= ~in_w[b];
      repeat (2) @(posedge clk_sys_in);
   endtask
   task automatic await_tasks(input int n, input int limit);
      for (int i = 0; i < limit; i++) begin
         if (order.size() >= n && task_busy === 1'b0) break;
         @(posedge clk_sys_in);
      end
      check("task count", 32'(n), 32'(order.size()));
   endtask

   initial begin
      repeat (60000) @(posedge clk_sys_in);
      mismatches++;
      $display("mismatch watchdog expected finish seen hang");
      conclude();
   end

   initial begin
      repeat (20) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_sys_in);
      rdx(8'h18, 32'h0020_003f, "status at reset");
      rdx(8'h10, 32'h0000_0000, "max time at reset");
      rdx(8'h14, 32'h0000_0000, "longest task at reset");
      rdx(8'h1c, 32'h0000_0000, "unmapped read");
      tog(2);
      rdx(8'h18, 32'h0020_003f, "masked input");
      tog(2);
      foreach (ROWS[i]) begin
         wr(ROWS[i].a, ROWS[i].d);
         rd(8'h18);
         check("status row", ROWS[i].s, v & 32'h0070_0fff);
      end
      rdx(8'h10, 32'h0000_0000, "read-only max time");
      // latching, discarding and edge polarity, all while disabled
      wr(8'h08, 32'h0000_0000);
      wr(8'h00, 32'h0068_0000);
      tog(4);
      rdx(8'h18, 32'h0000_403b, "edge latched");
      wr(8'h00, 32'h0069_0000);
      rdx(8'h18, 32'h0000_0033, "unmask discards");
      tog(4);
      tog(4);
      rdx(8'h18, 32'h0000_4033, "relatched");
      wr(8'h00, 32'h0074_0001);
      rdx(8'h18, 32'h0000_0433, "edge change discards");
      wr(8'h00, 32'h006a_0000);
      tog(6);
      rdx(8'h18, 32'h0000_0423, "rise ignored");
      tog(6);
      tog(5);
      tog(5);
      tog(5);
      rdx(8'h18, 32'h0001_8423, "falling and absorbed");
      wr(8'h04, 32'h0066_0000);
      rdx(8'h18, 32'h0001_8423, "clear keeps");
      wr(8'h04, 32'h0066_0001);
      rdx(8'h18, 32'h0000_0423, "clear drops");
      // several sources pending at once, then released together
      for (int n = 0; n < 6; n++) wr(8'h00, {16'(16'h0066 + n), 16'h0000});
      tog(7);
      tog(5);
      tog(5);
      tog(3);
      tog(6);
      tog(6);
      in_w <= in_w ^ 16'hff03;
      repeat (20) @(posedge clk_sys_in);
      rdx(8'h18, 32'h0003_a400, "pending while disabled");
      check("blocked", 32'h0, 32'(order.size()));
      wr(8'h0c, 32'h0000_0000);
      tog(3);
      tog(3);
      rdx(8'h18, 32'h002b_a400, "held while running");
      await_tasks(4, 1000);
      repeat (20) @(posedge clk_sys_in);
      check("order", 32'h3567, {order[0], order[1], order[2], order[3]});
      check("no extra task", 32'h4, 32'(order.size()));
      rdx(8'h18, 32'h0020_0400, "pending drained");
      rd(8'h14);
      check("first task tag", 32'h0000_8000, v & 32'h0000_fff0);
      // scheduled timer against a pending input, then run times
      wr(8'h08, 32'h0000_0000);
      tog(6);
      tog(6);
      run_len <= 16'h30d4;
      wr(8'h04, 32'h0004_0000);
      wr(8'h00, 32'h0004_000a);
      repeat (24980) @(posedge clk_sys_in);
      rd(8'h18);
      check("no early expiry", 32'h0, v & 32'h0004_0000);
      for (int i = 0; i < 20 && v[18] !== 1'b1; i++) rd(8'h18);
      check("interval expiry", 32'h0004_0000, v & 32'h0004_0000);
      wr(8'h0c, 32'h0000_0000);
      for (int i = 0; i < 100 && order.size() < 5; i++) begin
         @(posedge clk_sys_in);
      end
      run_len <= 16'h0028;
      await_tasks(6, 20000);
      check("input before scheduled", 32'h61, {order[4], order[5]});
      wr(8'h00, 32'h0004_0000);
      rdx(8'h14, 32'h0000_8006, "longest task");
      rd(8'h10);
      check("longest time", 32'h1, 32'(v >= 4 && v <= 6));
      // short first delay ahead of the interval, no dispatch while disabled
      wr(8'h08, 32'h0000_0000);
      wr(8'h04, 32'h0004_0003);
      wr(8'h00, 32'h0004_000a);
      repeat (7480) @(posedge clk_sys_in);
      rd(8'h18);
      check("no early first", 32'h0, v & 32'h0004_0000);
      for (int i = 0; i < 20 && v[18] !== 1'b1; i++) rd(8'h18);
      check("first delay", 32'h0004_0000, v & 32'h0004_0000);
      wr(8'h00, 32'h0004_0000);
      // restart of operation in mid-run clears the records
      sys_rst_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_sys_in);
      rdx(8'h14, 32'h0000_0000, "longest task after reset");
      rdx(8'h10, 32'h0000_0000, "max time after reset");
      rdx(8'h18, 32'h0020_003f, "status after reset");
      conclude();
   end
endmodule

// *** sim/plcic_seq_model.sv ***
// Purpose: task sequencer model that runs each dispatched interrupt task
// Assumes: one task at a time, run length set by the bench before start
// Notes: done is a one-cycle pulse, never in the start cycle
module plcic_seq_model (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   // task link
   input wire logic start_in,
   input wire logic [15:0] run_len_in,
   output logic done_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic active_reg;
   logic [15:0] left_reg;
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         active_reg <= 1'b0;
         left_reg <= 16'h0000;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (start_in) begin
            active_reg <= 1'b1;
            left_reg <= run_len_in;
         end else if (active_reg) begin
            // a run length of zero still waits one cycle after start
            if (left_reg <= 16'h0001) begin
               active_reg <= 1'b0;
               done_out <= 1'b1;
            end else begin
               left_reg <= left_reg - 16'h0001;
            end
         end
      end
   end
endmodule
